// [src/bps_defines.svh]
// timing counts and default codes for the buck power sequencer control
// assumes a 200 mhz core clock
`ifndef BPS_DEFINES_SVH
`define BPS_DEFINES_SVH
`define BPS_CLK_MHZ          200
`define BPS_OUTPUT_DISCHARGE_BIT_INIT_US   100
`define BPS_OUTPUT_DISCHARGE_BIT_INIT_CYC  (`BPS_OUTPUT_DISCHARGE_BIT_INIT_US * `BPS_CLK_MHZ)
`define BPS_SLEEP_EST_US     150
`define BPS_SLEEP_EST_CYC    (`BPS_SLEEP_EST_US * `BPS_CLK_MHZ)
`define BPS_DELAY_STEP_MS    2
`define BPS_DELAY_STEP_CYC   (`BPS_DELAY_STEP_MS * 1000 * `BPS_CLK_MHZ)
`define BPS_WAKE_US          800
`define BPS_WAKE_CYC         (`BPS_WAKE_US * `BPS_CLK_MHZ)
`define BPS_INIT_US          100
`define BPS_INIT_CYC         (`BPS_INIT_US * `BPS_CLK_MHZ)
`define BPS_FAST_US          20
`define BPS_FAST_CYC         (`BPS_FAST_US * `BPS_CLK_MHZ)
`define BPS_TPW_DEFAULT      2'h0
`define BPS_VOUT_MIN_UV      600000
`define BPS_VOUT_STEP_UV     6250
`define BPS_ILIM_00_MA       3400
`define BPS_ILIM_01_MA       4000
`define BPS_ILIM_10_MA       4400
`define BPS_ILIM_11_MA       5000
`endif

// [src/bps_pkg.sv]
// types for the buck power sequencer control
// no dependencies
package bps_pkg;
  typedef enum logic [2:0] {
    BPS_WAKE, BPS_OFF, BPS_SLEEP, BPS_DELAY, BPS_INIT, BPS_ON, BPS_TSD
  } bps_state_t;
  typedef enum logic [1:0] {
    BPS_SEQ_NONE, BPS_SEQ_NORMAL, BPS_SEQ_QUICK, BPS_SEQ_FAST
  } bps_seq_t;
endpackage

// [src/bps_sequencer.sv]
// sequencer, mode decision and protection control of a step-down converter
// assumes pins and analog detector outputs are asynchronous to CLK and
// that SYS_RST is the power-on reset derived from the lockout detector
//
// Functional notes
// R01 - current limit code maps 3.4/4.0/4.4/5.0 A
// R02 - voltage code: 0.6 V plus 6.25 mV steps
// R03 - setpoint a only when gating 1, select 0
// R04 - below lockout everything held in reset
// R05 - thermal trip armed only when on, interrupts
// R06 - after trip: thermal_restart_bit bit restarts, else enable toggle
// R07 - warning and prewarning interrupts, threshold field
// R08 - discharge enable bit, resets disabled
// R09 - discharge forced first 100 us after supply
// R10 - enable low: off; sleep if request or select
// R11 - enable high: run per selected on bit
// R12 - enable rising edge starts power-up sequencer
// R13 - wake-up interval unskippable, edge gives initial sequence
// R14 - user delay 2 ms units before init
// R15 - power-up voltage follows select signal then
// R16 - nack all i2c during wake-up
// R17 - rising enable from off: normal with delay
// R18 - rising enable from sleep: quick with delay
// R19 - on bit or select change: fast, no delay
// R20 - sleep established 150 us after entry
// R21 - immediate shutdown, discharge only if enabled
// R22 - core and registers alive while enable low
// R23 - pins and detectors synchronised before use
`timescale 1ns/1ps
`include "bps_defines.svh"

module bps_sequencer
  import bps_pkg::*;
#(
  parameter int WAKE_CYC   = `BPS_WAKE_CYC,
  parameter int INIT_CYC   = `BPS_INIT_CYC,
  parameter int FAST_CYC   = `BPS_FAST_CYC,
  parameter int DSTEP_CYC  = `BPS_DELAY_STEP_CYC,
  parameter int OUTPUT_DISCHARGE_BIT_CYC = `BPS_OUTPUT_DISCHARGE_BIT_INIT_CYC,
  parameter int SLEEP_CYC  = `BPS_SLEEP_EST_CYC
) (
  // clock and reset
  input  wire logic       CLK,
  input  wire logic       SYS_RST,
  // pins and analog detectors (asynchronous)
  input  wire logic       ENABLE_PIN,
  input  wire logic       VOLTAGE_SELECT_PIN,
  input  wire logic       THERMAL_SHUTDOWN_DET,
  input  wire logic       THERMAL_WARNING_DET,
  input  wire logic       THERMAL_PREWARNING_DET,
  // configuration bits
  input  wire logic       SETPOINT_A_ON_BIT,
  input  wire logic       SETPOINT_B_ON_BIT,
  input  wire logic [6:0] SETPOINT_A_VOLTAGE_CODE,
  input  wire logic [6:0] SETPOINT_B_VOLTAGE_CODE,
  input  wire logic       SELECT_PIN_GATING_BIT,
  input  wire logic       SLEEP_REQUEST_BIT,
  input  wire logic       THERMAL_RESTART_BIT,
  input  wire logic       OUTPUT_DISCHARGE_BIT,
  input  wire logic [1:0] INDUCTOR_CURRENT_LIMIT_CODE,
  input  wire logic [1:0] THERMAL_PREWARNING_THRESHOLD,
  input  wire logic [2:0] USER_DELAY_CODE,
  input  wire logic       INT_MASK_TSD,
  input  wire logic       INT_MASK_WARN,
  input  wire logic       INT_MASK_PREWARN,
  // converter core controls
  output logic            CONVERTER_ON,
  output logic            DISCHARGE_ON,
  output logic [6:0]      VOUT_CODE,
  output logic [20:0]     VOUT_SETPOINT_UV,
  output logic [12:0]     CURRENT_LIMIT_MA,
  output logic [1:0]      PREWARNING_TRIM,
  // status
  output logic            I2C_NACK_ALL,
  output logic            SLEEP_ESTABLISHED,
  output logic [2:0]      STATE,
  output logic [1:0]      LAST_SEQUENCE,
  output logic            INITIAL_SEQUENCE,
  // event pulses
  output logic            TSD_EVENT,
  output logic            WARN_EVENT,
  output logic            PREWARN_EVENT
);

  // ********************************************
  // input synchronisers
  // ********************************************
  localparam int NS = 5;
  logic [NS-1:0] async_in;
  logic [NS-1:0] s1_r;
  logic [NS-1:0] s2_r;
  logic [NS-1:0] s3_r;
  assign async_in = {THERMAL_PREWARNING_DET, THERMAL_WARNING_DET, THERMAL_SHUTDOWN_DET,
                     VOLTAGE_SELECT_PIN, ENABLE_PIN};

  // two flops per input then a history flop for edges
  genvar gi;
  generate
    for (gi = 0; gi < NS; gi++) begin : g_sync
      always_ff @(posedge CLK) begin
        if (SYS_RST) begin // [R04]
          s1_r[gi] <= 1'b0;
          s2_r[gi] <= 1'b0;
          s3_r[gi] <= 1'b0;
        end else begin // [R23]
          s1_r[gi] <= async_in[gi];
          s2_r[gi] <= s1_r[gi];
          s3_r[gi] <= s2_r[gi];
        end
      end
    end
  endgenerate

  logic en_s, voltage_select_pin_s, tsd_s, en_rise, voltage_select_pin_chg;
  assign en_s     = s2_r[0];
  assign voltage_select_pin_s   = s2_r[1];
  assign tsd_s    = s2_r[2];
  assign en_rise  = s2_r[0] & ~s3_r[0]; // [R12]
  assign voltage_select_pin_chg = s2_r[1] ^ s3_r[1];

  // ********************************************
  // setpoint selection and code mapping
  // ********************************************
  logic sel_a, sel_on;
  assign sel_a  = SELECT_PIN_GATING_BIT & ~voltage_select_pin_s; // [R03] [R15]
  assign sel_on = sel_a ? SETPOINT_A_ON_BIT : SETPOINT_B_ON_BIT;

  // data outputs are registered
  logic [6:0]  vcode_nxt;
  logic [20:0] vuv_nxt;
  logic [12:0] ilim_nxt;
  always_comb begin
    vcode_nxt = sel_a ? SETPOINT_A_VOLTAGE_CODE : SETPOINT_B_VOLTAGE_CODE;
    vuv_nxt = 21'(`BPS_VOUT_MIN_UV + 32'(vcode_nxt) * `BPS_VOUT_STEP_UV); // [R02]
    case (INDUCTOR_CURRENT_LIMIT_CODE) // [R01]
      2'h0:    ilim_nxt = 13'(`BPS_ILIM_00_MA);
      2'h1:    ilim_nxt = 13'(`BPS_ILIM_01_MA);
      2'h2:    ilim_nxt = 13'(`BPS_ILIM_10_MA);
      default: ilim_nxt = 13'(`BPS_ILIM_11_MA);
    endcase
  end

  // ********************************************
  // sequencer state machine
  // ********************************************
  bps_state_t state_r, state_nxt;
  bps_seq_t   seq_r, seq_nxt;
  logic [31:0] cnt_r, cnt_nxt;
  logic [31:0] slp_r, slp_nxt;
  logic [31:0] dis_r, dis_nxt;
  logic        pend_r, pend_nxt;      // enable edge seen during wake-up
  logic        init_r, init_nxt;
  logic        sel_on_q_r;
  logic        tsd_wait_r, tsd_wait_nxt; // tripped, waiting for enable toggle
  logic        wake_done;
  logic        on_cond;

  assign on_cond = en_s & sel_on; // [R11]
  assign wake_done = (state_r != BPS_WAKE);

  always_comb begin
    state_nxt    = state_r;
    seq_nxt      = seq_r;
    cnt_nxt      = (cnt_r != 32'h0) ? cnt_r - 32'h1 : 32'h0;
    pend_nxt     = pend_r;
    init_nxt     = init_r;
    tsd_wait_nxt = tsd_wait_r;
    if (en_rise) begin
      tsd_wait_nxt = 1'b0; // [R06]
    end
    case (state_r)
      BPS_WAKE: begin // [R13]
        if (en_rise) begin
          pend_nxt = 1'b1;
        end
        if (cnt_r == 32'h0) begin
          if (pend_nxt & on_cond) begin
            init_nxt  = 1'b1;
            seq_nxt   = BPS_SEQ_NORMAL;
            state_nxt = BPS_DELAY;
            cnt_nxt   = 32'(USER_DELAY_CODE) * 32'(DSTEP_CYC); // [R14]
          end else begin
            state_nxt = BPS_OFF;
          end
        end
      end
      BPS_OFF, BPS_SLEEP: begin
        if (en_rise & sel_on & ~tsd_wait_nxt) begin // [R17] [R18]
          init_nxt  = 1'b0;
          seq_nxt   = (state_r == BPS_OFF) ? BPS_SEQ_NORMAL : BPS_SEQ_QUICK;
          state_nxt = BPS_DELAY;
          cnt_nxt   = 32'(USER_DELAY_CODE) * 32'(DSTEP_CYC); // [R14]
        end else if (en_s & s3_r[0] & sel_on & ~sel_on_q_r & ~tsd_wait_r) begin // [R19]
          init_nxt  = 1'b0;
          seq_nxt   = BPS_SEQ_FAST;
          state_nxt = BPS_INIT;
          cnt_nxt   = 32'(FAST_CYC);
        end else if (en_s | SLEEP_REQUEST_BIT | voltage_select_pin_s) begin // [R10] [R11]
          state_nxt = BPS_SLEEP;
        end else begin
          state_nxt = BPS_OFF;
        end
      end
      BPS_DELAY: begin
        if (~on_cond) begin // [R21]
          state_nxt = en_s | SLEEP_REQUEST_BIT | voltage_select_pin_s ? BPS_SLEEP : BPS_OFF;
        end else if (cnt_r == 32'h0) begin
          state_nxt = BPS_INIT;
          cnt_nxt   = 32'(INIT_CYC);
        end
      end
      BPS_INIT: begin
        if (~on_cond) begin // [R21]
          state_nxt = en_s | SLEEP_REQUEST_BIT | voltage_select_pin_s ? BPS_SLEEP : BPS_OFF;
        end else if (cnt_r == 32'h0) begin
          state_nxt = BPS_ON;
        end
      end
      BPS_ON: begin
        if (tsd_s) begin // [R05]
          state_nxt    = BPS_TSD;
          tsd_wait_nxt = ~THERMAL_RESTART_BIT;
        end else if (~on_cond) begin // [R21]
          state_nxt = en_s | SLEEP_REQUEST_BIT | voltage_select_pin_s ? BPS_SLEEP : BPS_OFF; // [R10]
        end
      end
      BPS_TSD: begin
        if (~tsd_s) begin // [R06]
          if (~tsd_wait_nxt & on_cond) begin
            seq_nxt   = BPS_SEQ_FAST;
            state_nxt = BPS_INIT;
            cnt_nxt   = 32'(FAST_CYC);
          end else begin
            state_nxt = en_s | SLEEP_REQUEST_BIT | voltage_select_pin_s ? BPS_SLEEP : BPS_OFF;
          end
        end
      end
      default: state_nxt = BPS_OFF;
    endcase
    // a selection change while enabled restarts the fast path from sleep
    if (state_r == BPS_SLEEP && voltage_select_pin_chg && on_cond && !tsd_wait_r) begin // [R19]
      seq_nxt   = BPS_SEQ_FAST;
      state_nxt = BPS_INIT;
      cnt_nxt   = 32'(FAST_CYC);
    end
  end

  // sleep establishment and power-up discharge timers
  always_comb begin
    slp_nxt = (state_r != BPS_SLEEP) ? 32'(SLEEP_CYC) :
              ((slp_r != 32'h0) ? slp_r - 32'h1 : 32'h0); // [R20]
    dis_nxt = (dis_r != 32'h0) ? dis_r - 32'h1 : 32'h0;  // [R09]
  end

  // state registers; core logic stays alive with enable low
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin // [R04] [R22]
      state_r    <= BPS_WAKE;
      seq_r      <= BPS_SEQ_NONE;
      cnt_r      <= 32'(WAKE_CYC);
      pend_r     <= 1'b0;
      init_r     <= 1'b0;
      tsd_wait_r <= 1'b0;
      slp_r      <= 32'(SLEEP_CYC);
      dis_r      <= 32'(OUTPUT_DISCHARGE_BIT_CYC);
      sel_on_q_r <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      seq_r      <= seq_nxt;
      cnt_r      <= cnt_nxt;
      pend_r     <= pend_nxt;
      init_r     <= init_nxt;
      tsd_wait_r <= tsd_wait_nxt;
      slp_r      <= slp_nxt;
      dis_r      <= dis_nxt;
      sel_on_q_r <= sel_on;
    end
  end

  // ********************************************
  // outputs
  // ********************************************
  logic on_nxt, dis_on_nxt;
  logic tsd_ev_nxt, warn_ev_nxt, prew_ev_nxt;
  always_comb begin
    on_nxt      = (state_nxt == BPS_ON);
    dis_on_nxt  = (dis_nxt != 32'h0) | (~on_nxt & OUTPUT_DISCHARGE_BIT); // [R08] [R09] [R21]
    tsd_ev_nxt  = (state_r == BPS_ON) & tsd_s & ~INT_MASK_TSD;           // [R05]
    warn_ev_nxt = s2_r[3] & ~s3_r[3] & ~INT_MASK_WARN;                   // [R07]
    prew_ev_nxt = s2_r[4] & ~s3_r[4] & ~INT_MASK_PREWARN;                // [R07]
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      CONVERTER_ON     <= 1'b0;
      DISCHARGE_ON     <= 1'b1;
      VOUT_CODE        <= 7'h00;
      VOUT_SETPOINT_UV <= 21'(`BPS_VOUT_MIN_UV);
      CURRENT_LIMIT_MA <= 13'(`BPS_ILIM_00_MA);
      PREWARNING_TRIM  <= `BPS_TPW_DEFAULT;
      TSD_EVENT        <= 1'b0;
      WARN_EVENT       <= 1'b0;
      PREWARN_EVENT    <= 1'b0;
    end else begin
      CONVERTER_ON     <= on_nxt;
      DISCHARGE_ON     <= dis_on_nxt;
      VOUT_CODE        <= vcode_nxt;
      VOUT_SETPOINT_UV <= vuv_nxt;
      CURRENT_LIMIT_MA <= ilim_nxt;
      PREWARNING_TRIM  <= THERMAL_PREWARNING_THRESHOLD; // [R07]
      TSD_EVENT        <= tsd_ev_nxt;
      WARN_EVENT       <= warn_ev_nxt;
      PREWARN_EVENT    <= prew_ev_nxt;
    end
  end

  assign I2C_NACK_ALL      = ~wake_done; // [R16]
  assign SLEEP_ESTABLISHED = (state_r == BPS_SLEEP) & (slp_r == 32'h0); // [R20]
  assign STATE             = state_r;
  assign LAST_SEQUENCE     = seq_r;
  assign INITIAL_SEQUENCE  = init_r;

  // ********************************************
  // assertions
  // ********************************************
  property p_nack_wake; // [R16]
    @(posedge CLK) disable iff (SYS_RST) (state_r == BPS_WAKE) |-> I2C_NACK_ALL;
  endproperty
  a_nack_wake: assert property (p_nack_wake) else $error("i2c not refused in wake-up");

  property p_off_when_en_low; // [R10]
    @(posedge CLK) disable iff (SYS_RST) !en_s |=> !CONVERTER_ON;
  endproperty
  a_off_when_en_low: assert property (p_off_when_en_low) else $error("on with enable low");

  property p_tsd_off; // [R05]
    @(posedge CLK) disable iff (SYS_RST) (state_r == BPS_ON && tsd_s) |=> !CONVERTER_ON;
  endproperty
  a_tsd_off: assert property (p_tsd_off) else $error("on after thermal trip");

  property p_sel_a; // [R03]
    @(posedge CLK) disable iff (SYS_RST)
      (SELECT_PIN_GATING_BIT && !voltage_select_pin_s) |=> VOUT_CODE == $past(SETPOINT_A_VOLTAGE_CODE);
  endproperty
  a_sel_a: assert property (p_sel_a) else $error("wrong setpoint selected");

  property p_ilim; // [R01]
    @(posedge CLK) disable iff (SYS_RST)
      INDUCTOR_CURRENT_LIMIT_CODE == 2'h3 |=> CURRENT_LIMIT_MA == 13'(`BPS_ILIM_11_MA);
  endproperty
  a_ilim: assert property (p_ilim) else $error("current limit mapping wrong");

  property p_output_discharge_bit_init; // [R09]
    @(posedge CLK) disable iff (SYS_RST) (dis_r > 32'h1) |-> ##1 DISCHARGE_ON;
  endproperty
  a_output_discharge_bit_init: assert property (p_output_discharge_bit_init) else $error("initial discharge missing");

  property p_sleep_est; // [R20]
    @(posedge CLK) disable iff (SYS_RST)
      $rose(state_r == BPS_SLEEP) |-> !SLEEP_ESTABLISHED;
  endproperty
  a_sleep_est: assert property (p_sleep_est) else $error("sleep established too early");

  property p_no_on_in_wake; // [R13]
    @(posedge CLK) disable iff (SYS_RST) (state_r == BPS_WAKE) |-> !CONVERTER_ON;
  endproperty
  a_no_on_in_wake: assert property (p_no_on_in_wake) else $error("on during wake-up");

endmodule

// [sim/bps_host_model.sv]
// host side model: holds the configuration image seen by the sequencer
// assumes the bench calls put() just after a rising edge of clk
`timescale 1ns/1ps

module bps_host_model
  import bps_pkg::*;
(
  // clock and device status
  input  wire logic       clk,
  input  wire logic       i2c_nack_all,
  // configuration image
  output logic            a_on,
  output logic            b_on,
  output logic [6:0]      a_code,
  output logic [6:0]      b_code,
  output logic            gate,
  output logic            sleep_rq,
  output logic            restart,
  output logic            output_discharge_bit,
  output logic [1:0]      ilim,
  output logic [1:0]      tpw,
  output logic [2:0]      dly,
  output logic            m_tsd,
  output logic            m_warn,
  output logic            m_pre
);
  logic [6:0] cfg_r [14];

  // register image fields onto the device inputs
  assign {a_on, b_on, gate, sleep_rq} = {cfg_r[0][0], cfg_r[1][0], cfg_r[4][0], cfg_r[5][0]};
  assign {restart, output_discharge_bit, m_tsd} = {cfg_r[6][0], cfg_r[7][0], cfg_r[11][0]};
  assign {m_warn, m_pre} = {cfg_r[12][0], cfg_r[13][0]};
  assign {a_code, b_code, ilim} = {cfg_r[2], cfg_r[3], cfg_r[8][1:0]};
  assign {tpw, dly} = {cfg_r[9][1:0], cfg_r[10][2:0]};

  // all fields cleared, setpoint b enabled out of reset
  initial begin
    for (int i = 0; i < 14; i++) cfg_r[i] = 7'h00;
    cfg_r[1] = 7'h01;
  end

  // one register write; held back while the device refuses access
  task automatic put(input int id, input logic [6:0] v);
    int n;
    n = 0;
    while (i2c_nack_all === 1'b1 && n < 5000) begin
      @(posedge clk);
      n++;
    end
    @(posedge clk);
    #1 cfg_r[id] = v;
  endtask
endmodule

// [sim/test_buck_power_sequencer_control.sv]
// self-checking bench for the buck power sequencer control
// assumes bps_sequencer with shortened counts and the host model beside it
`timescale 1ns/1ps

module test_buck_power_sequencer_control
  import bps_pkg::*;
;
  localparam int WK = 20;
  localparam int IN = 10;
  localparam int FS = 5;
  localparam int DS = 50;
  logic clk = 1'b0, rst = 1'b1, en = 1'b0, voltage_select_pin = 1'b0, thermal_shutdown = 1'b0, wrn = 1'b0, pre = 1'b0;
  logic a_on, b_on, gate, sleep_rq, restart, output_discharge_bit, m_tsd, m_warn, m_pre;
  logic [6:0] a_code, b_code, vcode, c;
  logic [1:0] ilim, tpw, trim, seq;
  logic [2:0] dly, st;
  logic [20:0] uv;
  logic [12:0] ima;
  logic con, dis, nack, slp, ini, ev_t, ev_w, ev_p;
  int seed = 62, errors = 0, checked = 0, n = 0, tsd_n = 0, warn_n = 0, pre_n = 0;

  bps_host_model HOST (.clk(clk), .i2c_nack_all(nack), .a_on(a_on), .b_on(b_on),
    .a_code(a_code), .b_code(b_code), .gate(gate), .sleep_rq(sleep_rq), .restart(restart),
    .output_discharge_bit(output_discharge_bit), .ilim(ilim), .tpw(tpw), .dly(dly), .m_tsd(m_tsd), .m_warn(m_warn),
    .m_pre(m_pre));

  bps_sequencer #(.WAKE_CYC(WK), .INIT_CYC(IN), .FAST_CYC(FS), .DSTEP_CYC(DS),
    .OUTPUT_DISCHARGE_BIT_CYC(30), .SLEEP_CYC(40)) DUT (.CLK(clk), .SYS_RST(rst), .ENABLE_PIN(en),
    .VOLTAGE_SELECT_PIN(voltage_select_pin), .THERMAL_SHUTDOWN_DET(thermal_shutdown), .THERMAL_WARNING_DET(wrn),
    .THERMAL_PREWARNING_DET(pre), .SETPOINT_A_ON_BIT(a_on), .SETPOINT_B_ON_BIT(b_on),
    .SETPOINT_A_VOLTAGE_CODE(a_code), .SETPOINT_B_VOLTAGE_CODE(b_code),
    .SELECT_PIN_GATING_BIT(gate), .SLEEP_REQUEST_BIT(sleep_rq),
    .THERMAL_RESTART_BIT(restart), .OUTPUT_DISCHARGE_BIT(output_discharge_bit),
    .INDUCTOR_CURRENT_LIMIT_CODE(ilim), .THERMAL_PREWARNING_THRESHOLD(tpw),
    .USER_DELAY_CODE(dly), .INT_MASK_TSD(m_tsd), .INT_MASK_WARN(m_warn),
    .INT_MASK_PREWARN(m_pre), .CONVERTER_ON(con), .DISCHARGE_ON(dis), .VOUT_CODE(vcode),
    .VOUT_SETPOINT_UV(uv), .CURRENT_LIMIT_MA(ima), .PREWARNING_TRIM(trim),
    .I2C_NACK_ALL(nack), .SLEEP_ESTABLISHED(slp), .STATE(st), .LAST_SEQUENCE(seq),
    .INITIAL_SEQUENCE(ini), .TSD_EVENT(ev_t), .WARN_EVENT(ev_w), .PREWARN_EVENT(ev_p));

  // 200 mhz clock
  always #2.5 clk = ~clk;

  // count event pulses seen outside reset
  always @(posedge clk) if (!rst) begin
    tsd_n <= tsd_n + int'(ev_t === 1'b1);
    warn_n <= warn_n + int'(ev_w === 1'b1);
    pre_n <= pre_n + int'(ev_p === 1'b1);
  end

  // *****************************************
  // helpers
  // *****************************************
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  task automatic chk(input string nm, input logic [20:0] e, input logic [20:0] g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("BAD %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  // cycles until the converter runs, bounded
  task automatic wait_on();
    n = 0;
    while (con !== 1'b1 && n < 400) begin
      tick(1);
      n++;
    end
  endtask

  function automatic logic [20:0] ilim_of(input logic [1:0] k);
    case (k)
      2'h0: ilim_of = 21'h00d48;
      2'h1: ilim_of = 21'h00fa0;
      2'h2: ilim_of = 21'h01130;
      default: ilim_of = 21'h01388;
    endcase
  endfunction

  task automatic close_out();
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // watchdog cuts a hang short
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    close_out();
  end

  // *****************************************
  // main sequence
  // *****************************************
  initial begin
    tick(16);
    chk("nack", 1'b1, nack);
    chk("on", 1'b0, con);
    rst = 1'b0;
    tick(5);
    en = 1'b1;
    chk("dis", 1'b1, dis);
    wait_on();
    chk("initial_startup_sequence_time", 1'b1, n + 6 >= WK + IN);
    chk("ini", 1'b1, ini);
    chk("nack", 1'b0, nack);
    tick(15);
    chk("dis", 1'b0, dis);
    $display("test wake done");
    HOST.put(0, 7'h01);
    for (int i = 0; i < 24; i++) begin
      c = (i == 0) ? 7'h7f : (i == 1) ? 7'h00 : 7'($random(seed));
      HOST.put(2, c);
      HOST.put(3, 7'($random(seed)));
      HOST.put(4, 7'($random(seed)) & 7'h01);
      HOST.put(8, 7'($random(seed)) & 7'h03);
      HOST.put(9, 7'($random(seed)) & 7'h03);
      voltage_select_pin = 1'($random(seed));
      tick(5);
      c = (gate && !voltage_select_pin) ? a_code : b_code;
      chk("vout_code", c, vcode);
      chk("vout_uv", 21'h927c0 + 21'(c) * 21'h0186a, uv);
      chk("ilim", ilim_of(ilim), ima);
      chk("trim", tpw, trim);
    end
    voltage_select_pin = 1'b0;
    HOST.put(4, 7'h00);
    $display("test codes done");
    HOST.put(7, 7'h01);
    en = 1'b0;
    tick(5);
    chk("on", 1'b0, con);
    chk("dis", 1'b1, dis);
    chk("state", 3'h1, st);
    HOST.put(10, 7'h02);
    en = 1'b1;
    wait_on();
    chk("seq", 2'h1, seq);
    chk("normal_startup_sequence_time", 1'b1, n >= 2 * DS + IN && n <= 2 * DS + IN + 8);
    HOST.put(5, 7'h01);
    en = 1'b0;
    tick(5);
    chk("state", 3'h2, st);
    tick(30);
    chk("slp", 1'b0, slp);
    tick(15);
    chk("slp", 1'b1, slp);
    en = 1'b1;
    wait_on();
    chk("seq", 2'h2, seq);
    chk("quick_startup_sequence_time", 1'b1, n >= 2 * DS + IN);
    HOST.put(1, 7'h00);
    tick(4);
    chk("on", 1'b0, con);
    chk("state", 3'h2, st);
    HOST.put(1, 7'h01);
    wait_on();
    chk("seq", 2'h3, seq);
    chk("fast_startup_sequence_time", 1'b1, n <= FS + 6);
    $display("test modes done");
    thermal_shutdown = 1'b1;
    tick(5);
    chk("on", 1'b0, con);
    chk("tsd_ev", 1, tsd_n);
    thermal_shutdown = 1'b0;
    tick(20);
    chk("on", 1'b0, con);
    repeat (2) begin
      en = 1'b0;
      tick(5);
      en = 1'b1;
      tick(5);
    end
    wait_on();
    chk("on", 1'b1, con);
    HOST.put(6, 7'h01);
    thermal_shutdown = 1'b1;
    tick(5);
    chk("on", 1'b0, con);
    thermal_shutdown = 1'b0;
    wait_on();
    chk("on", 1'b1, con);
    en = 1'b0;
    tick(5);
    thermal_shutdown = 1'b1;
    tick(5);
    thermal_shutdown = 1'b0;
    chk("tsd_ev", 2, tsd_n);
    wrn = 1'b1;
    pre = 1'b1;
    tick(5);
    chk("warn_ev", 1, warn_n);
    chk("pre_ev", 1, pre_n);
    HOST.put(12, 7'h01);
    HOST.put(13, 7'h01);
    {wrn, pre} = 2'h0;
    tick(5);
    {wrn, pre} = 2'h3;
    tick(5);
    chk("warn_ev", 1, warn_n);
    chk("pre_ev", 1, pre_n);
    $display("test thermal done");
    chk("state", 3'h2, st);
    rst = 1'b1;
    tick(2);
    chk("state", 3'h0, st);
    chk("nack", 1'b1, nack);
    $display("test reset done");
    close_out();
  end
endmodule
